// >>> rtl/gss_status_srq.sv
// status byte, service request, addressing and byte handshake of a bus port
// assumes bus pins already synchronous to clk; open-drain pins are split into out/enable, with an input too for dio, dav, nrfd and ndac
`timescale 1ns/1ps

// Notes on behaviour
// - eight-bit status byte, overflow at bit 0 up to source fault at bit 7
// - controller polls: enable poll, address talk, read one byte, disable poll
// - with no request pending a read shows the live condition flags
// - each mask bit except bit 6 enables a request for the matching condition
// - on a request set bit 6 and freeze the status byte until read
// - overflow sets on over-range reading, clears on a later on-scale reading
// - store-full sets when stored count equals buffer size, clears on re-arm
// - store-half sets when count equals half the buffer size, clears on re-arm
// - reading-done sets on conversion done, clears once that reading is sent
// - ready is set when idle and clear while commands or triggers run
// - error sets on any error event, clears when error status word is read
// - request flag sets when service request asserted, clears on status read
// - source fault sets on limit or interlock, clears on word read after fault gone
// - service request line stays asserted until the status byte is read
// - primary address 0 to 31, listen address is primary or 20 hex
// - talk address is primary or 40 hex
// - secondary address bytes 60 to 7f hex are ignored
// - listener ready, talker valid, listener accepted, valid drops, ready again
// - addressed to talk, drive response one byte per handshake, one talker only
// - unlisten command leaves the listener state and stops taking data
// - all bus lines are low true
// - bytes with attention true are commands, otherwise device data
module gss_status_srq (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // instrument side
  input wire logic [4:0] primary_addr,
  input wire logic [7:0] mask_wdata,
  input wire logic mask_we,
  input wire logic reading_overrange,
  input wire logic reading_onscale,
  input wire logic [9:0] stored_count,
  input wire logic [9:0] buffer_size,
  input wire logic store_rearm,
  input wire logic conversion_done,
  input wire logic reading_sent,
  input wire logic busy,
  input wire logic error_event,
  input wire logic error_word_read,
  input wire logic vsource_fault,
  input wire logic vsource_word_read,
  input wire logic [7:0] resp_data,
  input wire logic resp_last,
  input wire logic resp_valid,
  output logic resp_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic [7:0] condition_status_byte,
  output logic [7:0] service_request_mask,
  output logic listener_active,
  output logic talker_active,
  output logic poll_mode,
  // bus pins, low true
  input wire logic [7:0] dio_n_in,
  output logic [7:0] dio_n_out,
  output logic [7:0] dio_n_oe_n,
  input wire logic atn_n,
  input wire logic dav_n_in,
  output logic dav_n_out,
  output logic dav_n_oe_n,
  input wire logic nrfd_n_in,
  output logic nrfd_n_out,
  output logic nrfd_n_oe_n,
  input wire logic ndac_n_in,
  output logic ndac_n_out,
  output logic ndac_n_oe_n,
  output logic eoi_n_out,
  output logic eoi_n_oe_n,
  output logic srq_n_out,
  output logic srq_n_oe_n
);

  // bus levels made true-high
  wire logic [7:0] bus_byte = ~dio_n_in;
  wire logic attention = ~atn_n;
  wire logic dav = ~dav_n_in;
  wire logic nrfd = ~nrfd_n_in;
  wire logic ndac = ~ndac_n_in;

  // condition flags
  logic [7:0] live;
  logic [7:0] frozen;
  logic request_pending_flag;
  logic reading_done_flag;
  logic overflow_flag;
  logic store_full_flag;
  logic store_half_flag;
  logic error_flag;
  logic vsource_fault_flag;
  wire logic idle_ready_flag = ~busy;
  wire logic [9:0] half_size = {1'b0, buffer_size[9:1]};

  always_comb begin
    live = 8'h00;
    live[gss_pkg::BIT_OVERFLOW] = overflow_flag;
    live[gss_pkg::BIT_STORE_FULL] = store_full_flag;
    live[gss_pkg::BIT_STORE_HALF] = store_half_flag;
    live[gss_pkg::BIT_READING_DONE] = reading_done_flag;
    live[gss_pkg::BIT_IDLE_READY] = idle_ready_flag;
    live[gss_pkg::BIT_ERROR] = error_flag;
    live[gss_pkg::BIT_VSOURCE] = vsource_fault_flag;
  end

  // mask has no bit 6
  wire logic [7:0] mask_eff = service_request_mask & ~(8'h01 << gss_pkg::BIT_REQUEST);
  wire logic raise_request = |(live & mask_eff) & ~request_pending_flag;

  // status byte shown: live while nothing pending, frozen copy afterwards
  wire logic [7:0] status_shown = request_pending_flag ? frozen : live;
  assign condition_status_byte = status_shown;

  // addresses
  wire logic [7:0] listen_addr = gss_pkg::LISTEN_BASE | {3'b000, primary_addr};
  wire logic [7:0] talk_addr = gss_pkg::TALK_BASE | {3'b000, primary_addr};
  wire logic [7:0] cmd = bus_byte & gss_pkg::CMD_MASK;
  wire logic is_secondary = (cmd & gss_pkg::GROUP_MASK) == gss_pkg::SECONDARY_BASE;

  // acceptor: byte taken on rising data valid while ready
  logic acc_hold;
  logic dav_seen;
  wire logic accept = dav & ~dav_seen & ~acc_hold;
  wire logic cmd_byte = accept & attention;
  wire logic data_byte = accept & ~attention & listener_active;
  wire logic acceptor_on = attention | listener_active;

  // source state
  gss_pkg::gss_src_t src_state;
  gss_pkg::gss_src_t next_src_state;
  logic [7:0] src_byte;
  logic src_last;
  logic poll_sent;
  wire logic src_have = poll_mode ? ~poll_sent : resp_valid;
  assign resp_ready = talker_active & ~poll_mode & ~attention & (src_state == gss_pkg::GSS_SRC_IDLE);

  always_comb begin
    next_src_state = src_state;
    unique case (src_state)
      gss_pkg::GSS_SRC_IDLE:
        if (talker_active & ~attention & src_have) begin
          next_src_state = gss_pkg::GSS_SRC_WAIT_READY;
        end
      gss_pkg::GSS_SRC_WAIT_READY:
        if (attention) begin
          next_src_state = gss_pkg::GSS_SRC_IDLE;
        end else if (~nrfd & ndac) begin
          next_src_state = gss_pkg::GSS_SRC_VALID;
        end
      gss_pkg::GSS_SRC_VALID:
        if (~ndac) begin
          next_src_state = gss_pkg::GSS_SRC_RELEASE;
        end
      gss_pkg::GSS_SRC_RELEASE:
        next_src_state = gss_pkg::GSS_SRC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      src_state <= gss_pkg::GSS_SRC_IDLE;
      src_byte <= 8'h00;
      src_last <= 1'b0;
    end else if (clk_en) begin
      src_state <= next_src_state;
      if (src_state == gss_pkg::GSS_SRC_IDLE && next_src_state == gss_pkg::GSS_SRC_WAIT_READY) begin
        src_byte <= poll_mode ? status_shown : resp_data;
        src_last <= poll_mode | resp_last;
      end
    end
  end

  // status read when the polled byte completes its handshake
  wire logic status_read = (src_state == gss_pkg::GSS_SRC_VALID) & ~ndac & poll_mode;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      service_request_mask <= gss_pkg::MASK_RESET;
    end else if (clk_en && mask_we) begin
      service_request_mask <= mask_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      request_pending_flag <= 1'b0;
      frozen <= 8'h00;
    end else if (clk_en) begin
      if (raise_request) begin
        request_pending_flag <= 1'b1;
        frozen <= live | (8'h01 << gss_pkg::BIT_REQUEST);
      end else if (status_read) begin
        request_pending_flag <= 1'b0;
      end
    end
  end

  // flags: set wins over clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overflow_flag <= 1'b0;
      store_full_flag <= 1'b0;
      store_half_flag <= 1'b0;
      reading_done_flag <= 1'b0;
      error_flag <= 1'b0;
      vsource_fault_flag <= 1'b0;
    end else if (clk_en) begin
      if (reading_overrange) begin
        overflow_flag <= 1'b1;
      end else if (reading_onscale) begin
        overflow_flag <= 1'b0;
      end
      if (buffer_size != 10'h000 && stored_count == buffer_size) begin
        store_full_flag <= 1'b1;
      end else if (store_rearm) begin
        store_full_flag <= 1'b0;
      end
      if (buffer_size != 10'h000 && stored_count == half_size) begin
        store_half_flag <= 1'b1;
      end else if (store_rearm) begin
        store_half_flag <= 1'b0;
      end
      if (conversion_done) begin
        reading_done_flag <= 1'b1;
      end else if (reading_sent) begin
        reading_done_flag <= 1'b0;
      end
      if (error_event) begin
        error_flag <= 1'b1;
      end else if (error_word_read) begin
        error_flag <= 1'b0;
      end
      if (vsource_fault) begin
        vsource_fault_flag <= 1'b1;
      end else if (vsource_word_read) begin
        vsource_fault_flag <= 1'b0;
      end
    end
  end

  // addressing and poll mode from command bytes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      listener_active <= 1'b0;
      talker_active <= 1'b0;
      poll_mode <= 1'b0;
    end else if (clk_en && cmd_byte && !is_secondary) begin
      if (cmd == gss_pkg::CMD_UNLISTEN) begin
        listener_active <= 1'b0;
      end else if (cmd == listen_addr) begin
        listener_active <= 1'b1;
      end
      if (cmd == gss_pkg::CMD_UNTALK) begin
        talker_active <= 1'b0;
      end else if (cmd == talk_addr) begin
        talker_active <= 1'b1;
      end else if ((cmd & gss_pkg::GROUP_MASK) == gss_pkg::TALK_BASE) begin
        talker_active <= 1'b0;
      end
      if (cmd == gss_pkg::CMD_POLL_ENABLE) begin
        poll_mode <= 1'b1;
      end else if (cmd == gss_pkg::CMD_POLL_DISABLE) begin
        poll_mode <= 1'b0;
      end
    end
  end

  // acceptor handshake and received data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_hold <= 1'b0;
      dav_seen <= 1'b0;
      poll_sent <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else if (clk_en) begin
      dav_seen <= dav;
      acc_hold <= dav ? (acc_hold | accept) : 1'b0;
      rx_valid <= data_byte;
      if (data_byte) begin
        rx_data <= bus_byte;
      end
      if (!poll_mode) begin
        poll_sent <= 1'b0;
      end else if (status_read) begin
        poll_sent <= 1'b1;
      end
    end
  end

  // pin drive: enable low means driving; a driven control line is pulled low (true), data lines drive the inverted byte
  wire logic src_drive = talker_active & ~attention & (src_state != gss_pkg::GSS_SRC_IDLE);
  wire logic acc_not_ready = acceptor_on & (dav | acc_hold);
  wire logic acc_not_accepted = acceptor_on & ~acc_hold;
  assign dio_n_out = ~src_byte;
  assign dio_n_oe_n = {8{~src_drive}};
  assign dav_n_out = 1'b0;
  assign dav_n_oe_n = ~(src_state == gss_pkg::GSS_SRC_VALID);
  assign eoi_n_out = 1'b0;
  assign eoi_n_oe_n = ~((src_state == gss_pkg::GSS_SRC_VALID) & src_last);
  assign nrfd_n_out = 1'b0;
  assign nrfd_n_oe_n = ~acc_not_ready;
  assign ndac_n_out = 1'b0;
  assign ndac_n_oe_n = ~acc_not_accepted;
  assign srq_n_out = 1'b0;
  assign srq_n_oe_n = ~request_pending_flag;

  // checks
  sequence seq_request_raised;
    raise_request && clk_en;
  endsequence

  sequence seq_line_held;
    !srq_n_oe_n && condition_status_byte[gss_pkg::BIT_REQUEST];
  endsequence

  AST_SRQ_RAISE: assert property (@(posedge clk) disable iff (!nrst)
    seq_request_raised |=> seq_line_held) else $error("request not raised");

  AST_SRQ_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    (!srq_n_oe_n && !(status_read && clk_en)) |=> !srq_n_oe_n) else $error("request line dropped early");

  AST_FROZEN: assert property (@(posedge clk) disable iff (!nrst)
    (request_pending_flag && !(status_read && clk_en)) |=> $stable(condition_status_byte))
    else $error("status byte changed while frozen");

  AST_LIVE: assert property (@(posedge clk) disable iff (!nrst)
    !request_pending_flag |-> condition_status_byte == live && !condition_status_byte[gss_pkg::BIT_REQUEST] &&
    condition_status_byte[gss_pkg::BIT_IDLE_READY] == !busy) else $error("live status not shown");

  AST_LISTEN: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && cmd_byte && cmd == listen_addr && cmd != gss_pkg::CMD_UNLISTEN) |=> listener_active)
    else $error("listen address not taken");

  AST_UNLISTEN: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && cmd_byte && cmd == gss_pkg::CMD_UNLISTEN) |=> !listener_active ##0 !rx_valid)
    else $error("still listening after unlisten");

  AST_TALK: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && cmd_byte && cmd == talk_addr) |=> talker_active) else $error("talk address not taken");

  AST_DAV_ORDER: assert property (@(posedge clk) disable iff (!nrst)
    $fell(dav_n_oe_n) |-> $past(src_state) == gss_pkg::GSS_SRC_WAIT_READY && !$past(nrfd))
    else $error("data valid before ready");

  AST_POLL_BYTE: assert property (@(posedge clk) disable iff (!nrst)
    (!dav_n_oe_n && poll_mode && $past(src_state) == gss_pkg::GSS_SRC_WAIT_READY && $past(poll_mode))
    |-> src_byte == $past(src_byte)) else $error("poll byte changed");

  AST_OVERFLOW: assert property (@(posedge clk) disable iff (!nrst)
    (clk_en && reading_overrange) |=> overflow_flag) else $error("overflow flag not set");

endmodule

// >>> rtl/gss_pkg.sv
// package for the bus status-byte and service-request block
// assumes a single 40 MHz clock domain, nothing imported elsewhere
package gss_pkg;
  localparam int unsigned CLK_MHZ = 40;
  // status byte bit positions
  localparam int unsigned BIT_OVERFLOW = 0;
  localparam int unsigned BIT_STORE_FULL = 1;
  localparam int unsigned BIT_STORE_HALF = 2;
  localparam int unsigned BIT_READING_DONE = 3;
  localparam int unsigned BIT_IDLE_READY = 4;
  localparam int unsigned BIT_ERROR = 5;
  localparam int unsigned BIT_REQUEST = 6;
  localparam int unsigned BIT_VSOURCE = 7;
  // reset values
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [4:0] PRIMARY_RESET = 5'h00;
  // address groups and bus commands (true-level byte values)
  localparam logic [7:0] LISTEN_BASE = 8'h20;
  localparam logic [7:0] TALK_BASE = 8'h40;
  localparam logic [7:0] SECONDARY_BASE = 8'h60;
  localparam logic [7:0] CMD_UNLISTEN = 8'h3f;
  localparam logic [7:0] CMD_UNTALK = 8'h5f;
  localparam logic [7:0] CMD_POLL_ENABLE = 8'h18;
  localparam logic [7:0] CMD_POLL_DISABLE = 8'h19;
  localparam logic [7:0] GROUP_MASK = 8'h60;
  localparam logic [7:0] CMD_MASK = 8'h7f;
  typedef enum logic [1:0] {
    GSS_SRC_IDLE,
    GSS_SRC_WAIT_READY,
    GSS_SRC_VALID,
    GSS_SRC_RELEASE
  } gss_src_t;
endpackage

// >>> verification/gss_ctl_model.sv
// bus controller model: sends command and data bytes, reads talker bytes
// assumes resolved low-true bus lines with pull-ups, driven at falling clk
`timescale 1ns/1ps
module gss_ctl_model (
  input wire logic clk,
  input wire logic [7:0] dio_w,
  input wire logic dav_w,
  input wire logic nrfd_w,
  input wire logic ndac_w,
  input wire logic eoi_w,
  output logic atn_n,
  output logic [7:0] dio_n,
  output logic dav_n,
  output logic nrfd_n,
  output logic ndac_n,
  output logic hung
);
  initial begin
    atn_n = 1'b1;
    dio_n = 8'hff;
    dav_n = 1'b1;
    nrfd_n = 1'b0;
    ndac_n = 1'b0;
    hung = 1'b0;
  end
  function automatic logic line(input int sel);
    case (sel)
      0: return dav_w;
      1: return nrfd_w;
      default: return ndac_w;
    endcase
  endfunction
  // bounded wait, flags a stalled handshake
  task automatic wait_line(input int sel, input logic lvl);
    for (int i = 0; i < 64 && line(sel) !== lvl; i++) @(negedge clk);
    if (line(sel) !== lvl) hung = 1'b1;
  endtask
  task automatic send(input logic [7:0] b, input logic atn);
    @(negedge clk);
    atn_n = ~atn;
    nrfd_n = 1'b1;
    ndac_n = 1'b1;
    dio_n = ~b;
    repeat (2) @(negedge clk);
    wait_line(1, 1'b1);
    dav_n = 1'b0;
    wait_line(2, 1'b1);
    @(negedge clk);
    dav_n = 1'b1;
    dio_n = 8'hff;
    repeat (2) @(negedge clk);
  endtask
  // lag holds off ready to model a slow listener
  task automatic recv(input int lag, output logic [7:0] b, output logic eoi);
    @(negedge clk);
    atn_n = 1'b1;
    nrfd_n = 1'b0;
    ndac_n = 1'b0;
    repeat (lag + 1) @(negedge clk);
    nrfd_n = 1'b1;
    wait_line(0, 1'b0);
    b = ~dio_w;
    eoi = ~eoi_w;
    nrfd_n = 1'b0;
    ndac_n = 1'b1;
    wait_line(0, 1'b1);
    ndac_n = 1'b0;
    @(negedge clk);
  endtask
endmodule

// >>> verification/tb_top.sv
// testbench for the status byte, service request and addressing block
// assumes the controller model as bus partner, single 40 MHz clock
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic busy = 1'b0;
  logic vfault = 1'b0;
  logic resp_valid = 1'b0;
  logic resp_last = 1'b1;
  logic [7:0] resp_data = 8'h3c;
  logic [8:0] pls = 9'h000;
  logic [7:0] mask_wdata = 8'h00;
  logic [9:0] stored_count = 10'h000;
  int n_mismatch = 0;
  int n_tests = 0;
  wire [7:0] rx_data, condition_status_byte, service_request_mask, dio_n_out, dio_n_oe_n, c_dio, dio_w;
  wire resp_ready, rx_valid, listener_active, talker_active, poll_mode, dav_n_out, dav_n_oe_n;
  wire nrfd_n_out, nrfd_n_oe_n, ndac_n_out, ndac_n_oe_n, eoi_n_out, eoi_n_oe_n, srq_n_out, srq_n_oe_n;
  wire c_atn, c_dav, c_nrfd, c_ndac, hung, dav_w, nrfd_w, ndac_w, eoi_w, srq_w;
  // open-drain resolution, released lines pulled high
  assign dio_w = c_dio & (dio_n_out | dio_n_oe_n);
  assign dav_w = c_dav & (dav_n_out | dav_n_oe_n);
  assign nrfd_w = c_nrfd & (nrfd_n_out | nrfd_n_oe_n);
  assign ndac_w = c_ndac & (ndac_n_out | ndac_n_oe_n);
  assign eoi_w = eoi_n_out | eoi_n_oe_n;
  assign srq_w = srq_n_out | srq_n_oe_n;
  gss_status_srq i_dut (.clk, .nrst, .clk_en(1'b1), .primary_addr(5'h14), .mask_wdata, .mask_we(pls[8]),
    .reading_overrange(pls[0]), .reading_onscale(pls[1]), .stored_count, .buffer_size(10'h00a),
    .store_rearm(pls[2]), .conversion_done(pls[3]), .reading_sent(pls[4]), .busy, .error_event(pls[5]),
    .error_word_read(pls[6]), .vsource_fault(vfault), .vsource_word_read(pls[7]), .resp_data, .resp_last,
    .resp_valid, .resp_ready, .rx_data, .rx_valid, .condition_status_byte, .service_request_mask,
    .listener_active, .talker_active, .poll_mode, .dio_n_in(dio_w), .dio_n_out, .dio_n_oe_n,
    .atn_n(c_atn), .dav_n_in(dav_w), .dav_n_out, .dav_n_oe_n, .nrfd_n_in(nrfd_w), .nrfd_n_out,
    .nrfd_n_oe_n, .ndac_n_in(ndac_w), .ndac_n_out, .ndac_n_oe_n, .eoi_n_out, .eoi_n_oe_n,
    .srq_n_out, .srq_n_oe_n);
  gss_ctl_model i_ctl (.clk, .dio_w, .dav_w, .nrfd_w, .ndac_w, .eoi_w, .atn_n(c_atn), .dio_n(c_dio),
    .dav_n(c_dav), .nrfd_n(c_nrfd), .ndac_n(c_ndac), .hung);
  int rx_cnt = 0;
  logic [7:0] rx_last = 8'h00;
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      rx_cnt <= rx_cnt + 1;
      rx_last <= rx_data;
    end
  end
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic pulse(input int k);
    @(negedge clk);
    pls[k] = 1'b1;
    @(negedge clk);
    pls = 9'h000;
  endtask
  task automatic nx();
    repeat (2) @(negedge clk);
  endtask
  task automatic t_reset();
    chk(service_request_mask, 8'h00);
    chk(condition_status_byte, 8'h10);
    busy = 1'b1;
    nx();
    chk(condition_status_byte, 8'h00);
    busy = 1'b0;
    nx();
  endtask
  task automatic t_flags();
    int k[7] = '{2, 0, 1, 3, 4, 5, 6};
    logic [7:0] e[7] = '{8'h10, 8'h11, 8'h10, 8'h18, 8'h10, 8'h30, 8'h10};
    stored_count = 10'h005;
    nx();
    chk(condition_status_byte, 8'h14);
    stored_count = 10'h00a;
    nx();
    chk(condition_status_byte, 8'h16);
    stored_count = 10'h000;
    nx();
    chk(condition_status_byte, 8'h16);
    for (int i = 0; i < 7; i++) begin
      pulse(k[i]);
      chk(condition_status_byte, e[i]);
    end
    vfault = 1'b1;
    nx();
    chk(condition_status_byte, 8'h90);
    pulse(7);
    chk(condition_status_byte, 8'h90);
    vfault = 1'b0;
    pulse(7);
    chk(condition_status_byte, 8'h10);
  endtask
  task automatic t_poll();
    logic [7:0] b;
    logic e;
    mask_wdata = 8'h28;
    pulse(8);
    chk(service_request_mask, 8'h28);
    pulse(0);
    nx();
    chk({7'h00, srq_w}, 8'h01);
    pulse(3);
    nx();
    chk(condition_status_byte, 8'h59);
    pulse(1);
    pulse(4);
    repeat (20) @(negedge clk);
    chk(condition_status_byte, 8'h59);
    chk({7'h00, srq_w}, 8'h00);
    i_ctl.send(gss_pkg::CMD_POLL_ENABLE, 1'b1);
    chk({7'h00, poll_mode}, 8'h01);
    i_ctl.send(8'h54, 1'b1);
    chk({7'h00, talker_active}, 8'h01);
    i_ctl.recv(3, b, e);
    chk(b, 8'h59);
    chk({7'h00, e}, 8'h01);
    i_ctl.send(gss_pkg::CMD_POLL_DISABLE, 1'b1);
    chk({7'h00, srq_w}, 8'h01);
    chk(condition_status_byte, 8'h10);
    @(negedge clk);
    resp_valid = 1'b1;
    // offer held until taken, then dropped at the next falling edge
    fork
      i_ctl.recv(0, b, e);
      begin
        @(posedge clk iff resp_ready === 1'b1);
        @(negedge clk);
        resp_valid = 1'b0;
      end
    join
    chk(b, 8'h3c);
    chk({7'h00, e}, 8'h01);
  endtask
  task automatic t_addr();
    i_ctl.send(8'h34, 1'b1);
    chk({7'h00, listener_active}, 8'h01);
    i_ctl.send(8'h74, 1'b1);
    chk({7'h00, listener_active}, 8'h01);
    i_ctl.send(8'ha5, 1'b0);
    chk(rx_last, 8'ha5);
    i_ctl.send(gss_pkg::CMD_UNLISTEN, 1'b1);
    chk({7'h00, listener_active}, 8'h00);
    i_ctl.send(8'h5a, 1'b0);
    chk(rx_cnt[7:0], 8'h01);
    i_ctl.send(gss_pkg::CMD_UNTALK, 1'b1);
    chk({7'h00, talker_active}, 8'h00);
    i_ctl.send(8'h54, 1'b1);
    chk({7'h00, talker_active}, 8'h01);
    // talk address of another device leaves us untalked
    i_ctl.send(8'h55, 1'b1);
    chk({7'h00, talker_active}, 8'h00);
    chk({7'h00, hung}, 8'h00);
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    nx();
    t_reset();
    t_flags();
    t_poll();
    t_addr();
    stop_test();
  end
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule
